// ---- src/adc_ctrl_consts.vh ----
// Overview of operation
// (R01) writing 1 to conversion_go starts a conversion, restarting any conversion under way
// (R02) conversion_go reads 1 while busy, hardware clears it, writing 0 does nothing
// (R03) single mode delivers one result after 5129 system clock cycles
// (R04) repeat mode refreshes the result registers every 256 system clock cycles
// (R05) reference level {hi,lo}: 00 external, 01 1.0 V, 10 2.0 V, 11 reserved
// (R06) ref_pin_drive 1 buffers internal reference onto the pin, 0 frees the pin
// (R07) single-ended codes 0-7 route inputs, C grounds amplifier, E temperature, F offset
// (R08) differential codes 0-A pick fixed pairs, F offset calibration, B-E reserved
// (R09) a reserved input code opens every analog input switch
// (R10) front_end_mode 000,001,100,101,111 valid; 010,011,110 reserved
// (R11) alarm flags set only by hardware, cleared by writing 1, 0 leaves them
// (R12) alarm enable 0 blocks its interrupt but the flag still sets
// (R13) 11-bit two's complement result: top eight bits high register, three bits low
// (R14) reading the high register latches the matching low bits for the next read
// (R15) repeat mode holds the latest result; single-shot result invalid while converting
// (R16) filter_overflow in the low register reports overflow for the current sample
// (R17) top eight bits above upper_limit (reset FF) raise the upper alarm
// (R18) threshold alarms are inactive in differential modes
// (R19) both result registers are read-only and undefined after reset
// (R20) completion interrupt only when converter enabled and both alarms disabled
// (R21) top eight bits below lower_limit raise the lower alarm
// (R22) offset calibration shorts the differential converter inputs together
// (R23) thresholds checked once per result, flags set on the cycle the result is written
// (R24) all sources share one request line, not cleared when the converter is disabled
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_W            14
`define IDX_CONTROL_ZERO 14'h0F70
`define IDX_CONTROL_ONE  14'h0F71
`define IDX_RESULT_HIGH  14'h0F72
`define IDX_RESULT_LOW   14'h0F73
`define IDX_HIGH_THRESH  14'h0F74

`define RSEL_CTL0   3'h0
`define RSEL_CTL1   3'h1
`define RSEL_RHI    3'h2
`define RSEL_RLO    3'h3
`define RSEL_UPLIM  3'h4
`define RSEL_NONE   3'h7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTL0_RST    8'h00
`define CTL1_RST    8'h80
`define UPLIM_RST   8'hFF

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define C0_GO       7
`define C0_REF_LO   6
`define C0_REF_PIN  5
`define C0_REPEAT   4
`define C0_SEL_MSB  3
`define C0_SEL_LSB  0
`define C1_REF_HI   7
`define C1_UFLAG    6
`define C1_LFLAG    5
`define C1_UEN      4
`define C1_LEN      3
`define C1_MODE_MSB 2
`define C1_MODE_LSB 0
`define RLO_DATA_MSB 7
`define RLO_DATA_LSB 5
`define RLO_OVF     0

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define REF_EXT     2'h0
`define REF_1V0     2'h1
`define REF_2V0     2'h2
`define REF_RSVD    2'h3

`define MODE_SE_UNBUF   3'h0
`define MODE_SE_BUF     3'h1
`define MODE_DF_UNBUF   3'h4
`define MODE_DF_BUF     3'h5
`define MODE_DF_GAIN20  3'h7

`define SEL_SE_LAST 4'h7
`define SEL_DF_LAST 4'hA
`define SEL_TIA_GND 4'hC
`define SEL_TEMP    4'hE
`define SEL_OFFCAL  4'hF

// ----------------------------------------------------------------
// timing in system clock cycles
// ----------------------------------------------------------------
`define SINGLE_CONV_CYCLES 13'h1409
`define REPEAT_CONV_CYCLES 13'h0100
`define CONV_CNT_W         13

`endif

// ---- src/adc_wb_slave.v ----
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_consts.vh"

module adc_wb_slave (
  input  wire                 sys_clk_in,
  input  wire                 sys_rst_in,
  input  wire                 ce_in,
  input  wire                 wb_cyc_in,
  input  wire                 wb_stb_in,
  input  wire                 wb_we_in,
  input  wire [15:0]          wb_adr_in,
  input  wire [3:0]           wb_sel_in,
  input  wire [7:0]           rdata_in,
  output wire [`IDX_W-1:0]    index_out,
  output wire                 wr_commit_out,
  output wire                 rd_commit_out,
  output wire [31:0]          wb_dat_out,
  output wire                 wb_ack_out
);

  reg        ack_ff;
  reg [7:0]  dat_ff;
  wire       request;

  // ----------------------------------------------------------------
  // classic cycle: ack one cycle after the request, dropped the next
  // ----------------------------------------------------------------
  assign request       = wb_cyc_in & wb_stb_in;
  assign index_out     = wb_adr_in[15:2];
  assign wr_commit_out = request & ack_ff & wb_we_in & wb_sel_in[0] & ce_in;
  assign rd_commit_out = request & ack_ff & ~wb_we_in & ce_in;
  assign wb_dat_out    = {24'h000000, dat_ff};
  assign wb_ack_out    = ack_ff;

  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ack_ff <= 1'b0;
      dat_ff <= 8'h00;
    end else if (ce_in) begin
      ack_ff <= request & ~ack_ff;
      if (request & ~ack_ff) begin
        dat_ff <= rdata_in;
      end
    end
  end

endmodule
`default_nettype wire

// ---- src/adc_conv_timer.v ----
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_consts.vh"

module adc_conv_timer #(
  parameter [`CONV_CNT_W-1:0] SINGLE_CYCLES = `SINGLE_CONV_CYCLES,
  parameter [`CONV_CNT_W-1:0] REPEAT_CYCLES = `REPEAT_CONV_CYCLES
) (
  input  wire sys_clk_in,
  input  wire sys_rst_in,
  input  wire ce_in,
  input  wire start_in,
  input  wire repeat_in,
  output wire busy_out,
  output wire done_out
);

  reg  [`CONV_CNT_W-1:0] cnt_ff;
  reg                    busy_ff;
  reg                    done_ff;
  wire [`CONV_CNT_W-1:0] last;

  assign last     = (repeat_in ? REPEAT_CYCLES : SINGLE_CYCLES) - 1'b1; // R03 R04
  assign busy_out = busy_ff;
  assign done_out = done_ff;

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cnt_ff  <= {`CONV_CNT_W{1'b0}};
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (ce_in) begin
      done_ff <= 1'b0;
      if (start_in) begin
        cnt_ff  <= {`CONV_CNT_W{1'b0}}; // R01
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (cnt_ff >= last) begin
          cnt_ff  <= {`CONV_CNT_W{1'b0}};
          done_ff <= 1'b1;
          busy_ff <= repeat_in; // R02 R04
        end else begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- src/adc_control_status_regs.v ----
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_consts.vh"

module adc_control_status_regs #(
  parameter [`CONV_CNT_W-1:0] SINGLE_CYCLES = `SINGLE_CONV_CYCLES
) (
  input  wire        sys_clk_in,
  input  wire        sys_rst_in,
  input  wire        ce_in,
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [15:0] wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output wire [31:0] wb_dat_out,
  output wire        wb_ack_out,
  input  wire [10:0] conv_sample_in,
  input  wire        conv_ovf_in,
  input  wire [7:0]  lower_limit_in,
  input  wire        adc_enable_in,
  input  wire        irq_ack_in,
  output wire        conv_start_out,
  output wire        conv_busy_out,
  output wire        result_strobe_out,
  output reg  [1:0]  ref_level_out,
  output reg         ref_internal_on_out,
  output reg         ref_pin_drive_out,
  output reg  [2:0]  front_end_mode_out,
  output reg         diff_mode_out,
  output reg         unity_buffer_on_out,
  output reg         gain20_on_out,
  output reg  [3:0]  input_select_out,
  output reg         input_switches_on_out,
  output reg         offset_short_out,
  output reg         tia_ground_out,
  output reg         temp_sensor_sel_out,
  output wire        irq_out
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function [2:0] reg_select;
    input [`IDX_W-1:0] idx;
    begin
      case (idx)
        `IDX_CONTROL_ZERO: reg_select = `RSEL_CTL0;
        `IDX_CONTROL_ONE:  reg_select = `RSEL_CTL1;
        `IDX_RESULT_HIGH:  reg_select = `RSEL_RHI;
        `IDX_RESULT_LOW:   reg_select = `RSEL_RLO;
        `IDX_HIGH_THRESH:  reg_select = `RSEL_UPLIM;
        default:           reg_select = `RSEL_NONE;
      endcase
    end
  endfunction

  function mode_is_diff;
    input [2:0] mode;
    begin
      mode_is_diff = mode[2];
    end
  endfunction

  function mode_reserved;
    input [2:0] mode;
    begin
      case (mode)
        `MODE_SE_UNBUF, `MODE_SE_BUF, `MODE_DF_UNBUF,
        `MODE_DF_BUF, `MODE_DF_GAIN20: mode_reserved = 1'b0; // R10
        default:                       mode_reserved = 1'b1;
      endcase
    end
  endfunction

  function sel_reserved;
    input [3:0] sel;
    input [2:0] mode;
    begin
      if (mode_is_diff(mode)) begin
        sel_reserved = (sel > `SEL_DF_LAST) && (sel != `SEL_OFFCAL); // R08
      end else begin
        sel_reserved = (sel > `SEL_SE_LAST) && (sel != `SEL_TIA_GND) &&
                       (sel != `SEL_TEMP) && (sel != `SEL_OFFCAL); // R07
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  wire [`IDX_W-1:0] index;
  wire              wr_commit;
  wire              rd_commit;
  reg  [7:0]        rdata;

  adc_wb_slave u_bus (
    .sys_clk_in    (sys_clk_in),
    .sys_rst_in    (sys_rst_in),
    .ce_in         (ce_in),
    .wb_cyc_in     (wb_cyc_in),
    .wb_stb_in     (wb_stb_in),
    .wb_we_in      (wb_we_in),
    .wb_adr_in     (wb_adr_in),
    .wb_sel_in     (wb_sel_in),
    .rdata_in      (rdata),
    .index_out     (index),
    .wr_commit_out (wr_commit),
    .rd_commit_out (rd_commit),
    .wb_dat_out    (wb_dat_out),
    .wb_ack_out    (wb_ack_out)
  );

  wire [2:0] rsel;
  wire [7:0] wdata;
  wire       wr_ctl0;
  wire       wr_ctl1;
  wire       wr_uplim;
  wire       rd_high;

  assign rsel     = reg_select(index);
  assign wdata    = wb_dat_in[7:0];
  assign wr_ctl0  = wr_commit & (rsel == `RSEL_CTL0);
  assign wr_ctl1  = wr_commit & (rsel == `RSEL_CTL1);
  assign wr_uplim = wr_commit & (rsel == `RSEL_UPLIM);
  assign rd_high  = rd_commit & (rsel == `RSEL_RHI);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  reg       ref_lo_ff;
  reg       ref_pin_ff;
  reg       repeat_ff;
  reg [3:0] sel_ff;
  reg       ref_hi_ff;
  reg       uflag_ff;
  reg       lflag_ff;
  reg       uen_ff;
  reg       len_ff;
  reg [2:0] mode_ff;
  reg [7:0] upper_limit_ff;

  wire      start_req;
  wire      busy;
  wire      done;
  wire      upper_hit;
  wire      lower_hit;

  assign start_req      = wr_ctl0 & wdata[`C0_GO]; // R01 R02
  assign conv_start_out = start_req;
  assign conv_busy_out  = busy;

  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ref_lo_ff      <= 1'b0;
      ref_pin_ff     <= 1'b0;
      repeat_ff      <= 1'b0;
      sel_ff         <= 4'h0;
      ref_hi_ff      <= 1'b1;
      uen_ff         <= 1'b0;
      len_ff         <= 1'b0;
      mode_ff        <= 3'h0;
      upper_limit_ff <= `UPLIM_RST; // R17
    end else if (ce_in) begin
      if (wr_ctl0) begin
        ref_lo_ff  <= wdata[`C0_REF_LO];
        ref_pin_ff <= wdata[`C0_REF_PIN];
        repeat_ff  <= wdata[`C0_REPEAT];
        sel_ff     <= wdata[`C0_SEL_MSB:`C0_SEL_LSB];
      end
      if (wr_ctl1) begin
        ref_hi_ff <= wdata[`C1_REF_HI];
        uen_ff    <= wdata[`C1_UEN]; // R12
        len_ff    <= wdata[`C1_LEN];
        mode_ff   <= wdata[`C1_MODE_MSB:`C1_MODE_LSB];
      end
      if (wr_uplim) begin
        upper_limit_ff <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // alarm flags: hardware set wins over a write-one clear
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      uflag_ff <= 1'b0;
      lflag_ff <= 1'b0;
    end else if (ce_in) begin
      if (upper_hit) begin
        uflag_ff <= 1'b1; // R11 R23
      end else if (wr_ctl1 & wdata[`C1_UFLAG]) begin
        uflag_ff <= 1'b0; // R11
      end
      if (lower_hit) begin
        lflag_ff <= 1'b1; // R11 R23
      end else if (wr_ctl1 & wdata[`C1_LFLAG]) begin
        lflag_ff <= 1'b0; // R11
      end
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  adc_conv_timer #(
    .SINGLE_CYCLES (SINGLE_CYCLES)
  ) u_timer (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .start_in   (start_req),
    .repeat_in  (repeat_ff),
    .busy_out   (busy),
    .done_out   (done)
  );

  assign result_strobe_out = done;

  // ----------------------------------------------------------------
  // result registers, no reset: high undefined until first result, low until the first high read after it
  // ----------------------------------------------------------------
  reg [7:0] res_hi_ff;
  reg [2:0] res_lo_ff;
  reg       res_ovf_ff;
  reg [2:0] lo_view_ff;
  reg       ovf_view_ff;

  always @(posedge sys_clk_in) begin
    if (ce_in) begin
      if (done) begin
        res_hi_ff  <= conv_sample_in[10:3]; // R13 R15
        res_lo_ff  <= conv_sample_in[2:0];
        res_ovf_ff <= conv_ovf_in; // R16
      end
      if (rd_high) begin
        lo_view_ff  <= res_lo_ff; // R14
        ovf_view_ff <= res_ovf_ff; // R16
      end
    end
  end

  // ----------------------------------------------------------------
  // threshold compare on each new result, single-ended only
  // ----------------------------------------------------------------
  wire [7:0] new_top;
  wire       alarm_live;

  assign new_top    = conv_sample_in[10:3];
  assign alarm_live = done & ~mode_is_diff(mode_ff); // R18 R23
  assign upper_hit  = alarm_live & (new_top > upper_limit_ff); // R17
  assign lower_hit  = alarm_live & (new_top < lower_limit_in); // R21

  // ----------------------------------------------------------------
  // shared interrupt request
  // ----------------------------------------------------------------
  reg  irq_ff;
  wire irq_event;

  assign irq_event = adc_enable_in &
                     ((upper_hit & uen_ff) | (lower_hit & len_ff) |
                      (done & ~uen_ff & ~len_ff)); // R12 R20 R24
  assign irq_out   = irq_ff;

  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      irq_ff <= 1'b0;
    end else if (ce_in) begin
      if (irq_event) begin
        irq_ff <= 1'b1; // R24
      end else if (irq_ack_in) begin
        irq_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read data mux, reserved bits read zero
  // ----------------------------------------------------------------
  always @* begin
    rdata = 8'h00;
    case (rsel)
      `RSEL_CTL0: begin
        rdata[`C0_GO]                  = busy; // R02
        rdata[`C0_REF_LO]              = ref_lo_ff;
        rdata[`C0_REF_PIN]             = ref_pin_ff;
        rdata[`C0_REPEAT]              = repeat_ff;
        rdata[`C0_SEL_MSB:`C0_SEL_LSB] = sel_ff;
      end
      `RSEL_CTL1: begin
        rdata[`C1_REF_HI]                = ref_hi_ff;
        rdata[`C1_UFLAG]                 = uflag_ff;
        rdata[`C1_LFLAG]                 = lflag_ff;
        rdata[`C1_UEN]                   = uen_ff;
        rdata[`C1_LEN]                   = len_ff;
        rdata[`C1_MODE_MSB:`C1_MODE_LSB] = mode_ff;
      end
      `RSEL_RHI: begin
        rdata = res_hi_ff; // R19
      end
      `RSEL_RLO: begin
        rdata[`RLO_DATA_MSB:`RLO_DATA_LSB] = lo_view_ff; // R19
        rdata[`RLO_OVF]                    = ovf_view_ff;
      end
      `RSEL_UPLIM: begin
        rdata = upper_limit_ff;
      end
      default: begin
        rdata = 8'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // analog front-end controls, registered
  // ----------------------------------------------------------------
  wire [1:0] ref_level;
  wire       path_open;

  assign ref_level = {ref_hi_ff, ref_lo_ff};
  assign path_open = sel_reserved(sel_ff, mode_ff) | mode_reserved(mode_ff); // R09

  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ref_level_out         <= `REF_2V0;
      ref_internal_on_out   <= 1'b1;
      ref_pin_drive_out     <= 1'b0;
      front_end_mode_out    <= `MODE_SE_UNBUF;
      diff_mode_out         <= 1'b0;
      unity_buffer_on_out   <= 1'b0;
      gain20_on_out         <= 1'b0;
      input_select_out      <= 4'h0;
      input_switches_on_out <= 1'b0;
      offset_short_out      <= 1'b0;
      tia_ground_out        <= 1'b0;
      temp_sensor_sel_out   <= 1'b0;
    end else if (ce_in) begin
      ref_level_out         <= ref_level;
      ref_internal_on_out   <= (ref_level == `REF_1V0) | (ref_level == `REF_2V0); // R05
      ref_pin_drive_out     <= ref_pin_ff; // R06
      front_end_mode_out    <= mode_ff; // R10
      diff_mode_out         <= mode_is_diff(mode_ff) & ~mode_reserved(mode_ff);
      unity_buffer_on_out   <= (mode_ff == `MODE_SE_BUF) | (mode_ff == `MODE_DF_BUF);
      gain20_on_out         <= (mode_ff == `MODE_DF_GAIN20);
      input_select_out      <= sel_ff;
      input_switches_on_out <= ~path_open; // R09
      offset_short_out      <= ~path_open & (sel_ff == `SEL_OFFCAL); // R22
      tia_ground_out        <= ~path_open & ~mode_is_diff(mode_ff) &
                               (sel_ff == `SEL_TIA_GND); // R07
      temp_sensor_sel_out   <= ~path_open & ~mode_is_diff(mode_ff) &
                               (sel_ff == `SEL_TEMP); // R07
    end
  end

endmodule
`default_nettype wire

// ---- dv/adc_regs_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_consts.vh"
module adc_regs_monitor #(
  parameter [`CONV_CNT_W-1:0] SINGLE_CYCLES = `SINGLE_CONV_CYCLES
) (
  input wire logic        sys_clk_in,
  input wire logic        sys_rst_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic        wb_ack_out,
  input wire logic        conv_start_out,
  input wire logic        conv_busy_out,
  input wire logic        result_strobe_out,
  input wire logic [1:0]  ref_level_out,
  input wire logic        ref_internal_on_out,
  input wire logic        irq_out
);
  // ------------------------------
  // cycles since the last start
  // ------------------------------
  logic [13:0] cnt_ff;
  logic        rep_ff;
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cnt_ff <= 14'h0000;
      rep_ff <= 1'b0;
    end else begin
      cnt_ff <= conv_start_out ? 14'h0000 : cnt_ff + 14'h0001;
      if (conv_start_out) begin
        rep_ff <= wb_dat_in[`C0_REPEAT];
      end
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  chk_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("request not acknowledged next cycle");
  chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("acknowledge longer than one cycle");
  chk_start_busy: assert property (conv_start_out |=> conv_busy_out)
    else $error("start did not raise busy");
  chk_single_time: assert property (result_strobe_out && !rep_ff |-> cnt_ff == SINGLE_CYCLES)
    else $error("single result at wrong cycle");
  chk_repeat_period: assert property (result_strobe_out && rep_ff |-> cnt_ff[7:0] == 8'h00)
    else $error("repeat result off its period");
  chk_busy_drop: assert property (result_strobe_out && !rep_ff && !conv_start_out |=> !conv_busy_out)
    else $error("busy kept after single result");
  chk_irq_cause: assert property ($rose(irq_out) |-> $past(result_strobe_out))
    else $error("request raised without a result");
  chk_ref_decode: assert property (ref_internal_on_out == (ref_level_out == 2'h1 || ref_level_out == 2'h2))
    else $error("internal reference state wrong");
endmodule
`default_nettype wire

// ---- dv/adc_core_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// converter core, new sample each result
// ------------------------------
module adc_core_model (
  input  wire logic   clk_in,
  input  wire logic   strobe_in,
  output logic [10:0] sample_out,
  output logic        ovf_out,
  output logic [11:0] last_out
);
  logic [11:0] pend_ff = 12'hA5C;
  // lines are valid only while the result is taken
  assign sample_out = strobe_in ? pend_ff[10:0] : ~pend_ff[10:0];
  assign ovf_out    = strobe_in ? pend_ff[11] : ~pend_ff[11];
  always @(posedge clk_in) begin
    if (strobe_in) begin
      last_out <= pend_ff;
      pend_ff  <= 12'($urandom);
    end
  end
endmodule
`default_nettype wire

// ---- dv/adc_control_status_regs_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_consts.vh"
module adc_control_status_regs_tb;
  localparam int N = 20;
  logic        clk, ack, busy, strb, irq, ovf, ri, rp, df, ub, g2, sw, os, tg, ts;
  logic        rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, iack = 1'b0, en = 1'b1;
  logic [1:0]  rl;
  logic [2:0]  fm;
  logic [3:0]  isel;
  logic [7:0]  th, lo = 8'h00;
  logic [10:0] smp;
  logic [11:0] last;
  logic [15:0] adr = 16'h0000;
  logic [31:0] rdat, dat = 32'h00000000;
  int          ncyc = 0, checked = 0, miscompares = 0;

  adc_control_status_regs #(.SINGLE_CYCLES(13'h0014)) dut (
    .sys_clk_in(clk), .sys_rst_in(rst), .ce_in(1'b1), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(dat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .conv_sample_in(smp), .conv_ovf_in(ovf), .lower_limit_in(lo),
    .adc_enable_in(en), .irq_ack_in(iack), .conv_start_out(), .conv_busy_out(busy),
    .result_strobe_out(strb), .ref_level_out(rl), .ref_internal_on_out(ri), .ref_pin_drive_out(rp),
    .front_end_mode_out(fm), .diff_mode_out(df), .unity_buffer_on_out(ub), .gain20_on_out(g2),
    .input_select_out(isel), .input_switches_on_out(sw), .offset_short_out(os),
    .tia_ground_out(tg), .temp_sensor_sel_out(ts), .irq_out(irq));
  adc_core_model core (.clk_in(clk), .strobe_in(strb), .sample_out(smp), .ovf_out(ovf), .last_out(last));

  // ------------------------------
  // clock, cycle count, watchdog
  // ------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) ncyc <= ncyc + 1;
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  // ------------------------------
  // bus cycles
  // ------------------------------
  task automatic bus(input logic w, input logic [13:0] ix, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {ix, 2'h0};
    dat <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    chk({15'h0000, ack}, 16'h0001);
  endtask

  task automatic wr(input logic [13:0] ix, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, ix, d, q);
  endtask

  task automatic rd(input logic [13:0] ix, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, ix, 8'h00, q);
    chk({8'h00, q}, {8'h00, e});
  endtask

  task automatic wstb(output int t);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (strb !== 1'b1 && n < 600);
    t = ncyc;
    chk({15'h0000, strb}, 16'h0001);
  endtask

  // single conversion with alarm and request expectations
  task automatic conv(input logic [7:0] c1, input logic [7:0] c0, input logic [7:0] l);
    int t0, t1;
    logic up, dn, ir;
    logic [7:0] h;
    lo <= l;
    iack <= 1'b1;
    wr(`IDX_CONTROL_ONE, c1 | 8'h60);
    iack <= 1'b0;
    rd(`IDX_CONTROL_ONE, c1);
    wr(`IDX_CONTROL_ZERO, c0 | 8'h80);
    t0 = ncyc + 1;
    rd(`IDX_CONTROL_ZERO, c0 | 8'h80);
    wr(`IDX_CONTROL_ZERO, c0);
    wstb(t1);
    chk(16'(t1 - t0), 16'(N));
    @(posedge clk);
    h = last[10:3];
    up = !c1[2] && h > th;
    dn = !c1[2] && h < l;
    ir = en && ((c1[4] && up) || (c1[3] && dn) || !(c1[4] || c1[3]));
    chk({busy, irq}, {1'b0, ir});
    rd(`IDX_RESULT_HIGH, h);
    rd(`IDX_RESULT_LOW, {last[2:0], 4'h0, last[11]});
    wr(`IDX_CONTROL_ONE, c1);
    rd(`IDX_CONTROL_ONE, {c1[7], up, dn, c1[4:0]});
  endtask

  initial begin
    int m, s, t0, t1, t2;
    logic e;
    logic [11:0] v;
    void'($urandom(9073));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(`IDX_CONTROL_ZERO, `CTL0_RST);
    rd(`IDX_CONTROL_ONE, `CTL1_RST);
    rd(`IDX_HIGH_THRESH, `UPLIM_RST);
    rd(14'h0F75, 8'h00);
    th = 8'($urandom);
    wr(`IDX_HIGH_THRESH, th);
    rd(`IDX_HIGH_THRESH, th);
    for (m = 0; m < 8; m++) begin
      for (s = 0; s < 16; s++) begin
        wr(`IDX_CONTROL_ONE, {m[0], 4'h0, m[2:0]});
        wr(`IDX_CONTROL_ZERO, {1'b0, m[1], s[1], 1'b0, s[3:0]});
        repeat (2) @(posedge clk);
        e = !(m == 2 || m == 3 || m == 6) && (m[2] ? (s < 11 || s == 15) : (s < 8 || s == 12 || s > 13));
        chk({rl, ri, rp}, {m[0], m[1], m[0] ^ m[1], s[1]});
        chk({fm, df, ub, g2}, {m[2:0], m[2] && m != 6, m[1:0] == 2'h1, m == 7});
        chk({isel, sw, os, tg, ts}, {s[3:0], e, e && s == 15, e && !m[2] && s == 12, e && !m[2] && s == 14});
      end
    end
    wr(`IDX_CONTROL_ZERO, 8'h80);
    conv(8'h10, 8'h00, 8'h00);
    conv(8'h08, 8'h01, 8'hFF);
    conv(8'h00, 8'h43, 8'($urandom));
    en <= 1'b0;
    repeat (2) @(posedge clk);
    chk({15'h0000, irq}, 16'h0001);
    conv(8'h00, 8'h02, 8'($urandom));
    en <= 1'b1;
    conv(8'h9D, 8'h0F, 8'hFF);
    wr(`IDX_CONTROL_ONE, 8'h00);
    wr(`IDX_CONTROL_ZERO, 8'h90);
    t0 = ncyc + 1;
    wstb(t1);
    wstb(t2);
    chk(16'(t1 - t0), 16'h0100);
    chk(16'(t2 - t1), 16'h0100);
    @(posedge clk);
    v = last;
    rd(`IDX_RESULT_HIGH, v[10:3]);
    wstb(t1);
    rd(`IDX_RESULT_LOW, {v[2:0], 4'h0, v[11]});
    rd(`IDX_RESULT_HIGH, last[10:3]);
    wr(`IDX_CONTROL_ZERO, 8'h80);
    wstb(t1);
    complete_run();
  end
endmodule

bind adc_control_status_regs adc_regs_monitor #(.SINGLE_CYCLES(SINGLE_CYCLES)) mon (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out), .conv_start_out(conv_start_out),
  .conv_busy_out(conv_busy_out), .result_strobe_out(result_strobe_out), .ref_level_out(ref_level_out),
  .ref_internal_on_out(ref_internal_on_out), .irq_out(irq_out));
`default_nettype wire
